// >>> hw/ums_pkg.sv
// package for the modem status and reset-state logic of one serial channel
package ums_pkg;
    // register addresses on the three channel address lines
    localparam logic [2:0] ADDR_RX_TX = 3'h0; // data bytes, or divisor low when latch selected
    localparam logic [2:0] ADDR_ENABLE = 3'h1; // event enable, or divisor high when latch selected
    localparam logic [2:0] ADDR_SOURCE = 3'h2; // event source on read, queue control on write
    localparam logic [2:0] ADDR_FORMAT = 3'h3; // line format
    localparam logic [2:0] ADDR_MOCTL = 3'h4; // modem output control
    localparam logic [2:0] ADDR_LSTATE = 3'h5; // line state
    localparam logic [2:0] ADDR_MSTATE = 3'h6; // modem input state
    localparam logic [2:0] ADDR_SCRATCH = 3'h7; // scratch byte
    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_QUEUE = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_MOCTL = 8'h00;
    localparam logic [7:0] RST_SOURCE = 8'h01;
    localparam logic [7:0] RST_LSTATE = 8'h60;
    localparam logic [7:0] RST_SCRATCH = 8'hff;
    localparam logic [7:0] SOURCE_MODEM = 8'h00; // pending modem-status event code
    // field positions
    localparam int FMT_DLAB = 7; // divisor latch select in line format
    localparam int MOC_DTR = 0; // terminal-ready output control
    localparam int MOC_RTS = 1; // request-to-send output control
    localparam int MOC_OUT1 = 2; // spare output, ring in loopback
    localparam int MOC_OUT2 = 3; // event line enable, carrier in loopback
    localparam int MOC_LOOP = 4; // local loopback
    localparam int EN_MODEM = 3; // modem status event enable
    localparam int SYNC_STAGES = 3; // pin synchroniser depth

    // modem handshake inputs, active low at the pins
    typedef struct packed {
        logic carrier_detect_n;
        logic ring_indicator_n;
        logic data_set_ready_n;
        logic clear_to_send_n;
    } ums_modem_t;

    // host strobe bundle
    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ums_host_t;
endpackage

// >>> hw/ums_channel.sv
// modem status, transmit gating, scratch, divisor and reset state of one channel
//
// Behaviour
// R01: carrier change sets flag, event if enabled
// R02: clear-to-send high pauses transmit after character
// R03: status bit 4 inverted cts or rts
// R04: status bit 5 inverted dsr or dtr
// R05: status bit 6 inverted ring or out1
// R06: status bit 7 inverted carrier or out2
// R07: handshake inputs readable as general inputs
// R08: free 8-bit scratch byte
// R09: divisor is high byte then low byte
// R10: divisor bytes unaffected by reset
// R11: channel registers take documented reset values
// R12: change flags clear, levels shown on reset
// R13: event line drive follows select and enable
// R14: cts and dsr changes set their flags
// R15: ring flag only on low-to-high ring
// R16: status read clears all change flags
// R17: serial pins take documented idle levels
module ums_channel
    import ums_pkg::*;
#(
    parameter bit CONTINUOUS_EVENT = 1'b0 // continuous-output variant of the event line
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire ums_pkg::ums_host_t host,
    output logic [7:0] rdata,
    input wire ums_pkg::ums_modem_t modem_pins,
    input wire logic event_line_drive_select,
    input wire logic char_done,
    input wire logic rx_event,
    input wire logic [7:0] rx_hold_byte,
    output logic tx_enable,
    output logic [7:0] tx_hold_byte,
    output logic tx_load,
    output logic [15:0] baud_divisor,
    output logic [7:0] line_format_reg,
    output logic [7:0] queue_ctrl_reg,
    output logic serial_tx_out,
    output logic infrared_tx_out,
    output logic rts_out_n,
    output logic dtr_out_n,
    output logic rx_dma_request_n,
    output logic tx_dma_request_n,
    output logic event_out,
    output logic event_out_oe,
    output logic irq_out_n
);
    import ums_pkg::*;

    // pin synchroniser: three stages, change counted when 2nd and 3rd agree
    logic [3:0] sync1, sync2, sync3;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            sync3 <= 4'hf;
        end else begin
            sync1 <= modem_pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    logic [3:0] pin_lvl; // settled pin levels {cd,ri,dsr,cts}
    logic [3:0] next_pin_lvl;
    // flags stay quiet until a pin sample has crossed the synchroniser and the
    // previous-level register, else the reset value of the chain reads as a change;
    // a real pin change inside this short window after release is not flagged
    localparam int PRIME_CYCLES = SYNC_STAGES + 2;
    logic [2:0] prime_cnt, next_prime_cnt; // edges since reset release, saturating
    logic lvl_primed; // previous level register holds a settled sample
    assign lvl_primed = (prime_cnt == 3'(PRIME_CYCLES));
    // count release edges until the first settled sample is registered
    always_comb begin
        next_prime_cnt = prime_cnt;
        if (!lvl_primed) next_prime_cnt = prime_cnt + 3'h1;
    end
    always_comb begin
        // only update when the two late stages agree
        next_pin_lvl = pin_lvl;
        for (int i = 0; i < 4; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pin_lvl[i] = sync3[i];
            end
        end
    end

    // control registers
    logic [7:0] event_enable_reg, modem_output_ctrl_reg, scratch_byte_reg;
    logic [7:0] divisor_low_byte, divisor_high_byte;
    logic [7:0] next_enable, next_queue, next_format, next_moctl, next_scratch;
    logic [7:0] next_dll, next_dlm;
    logic [3:0] change_flags, next_flags;
    logic loop_mode;
    logic dlab;
    logic wr_hit, rd_hit;
    assign wr_hit = host.sel && host.wr;
    assign rd_hit = host.sel && host.rd;
    assign loop_mode = modem_output_ctrl_reg[MOC_LOOP];
    assign dlab = line_format_reg[FMT_DLAB];

    // effective modem levels, active high: inverted pins or loopback bits
    logic [3:0] eff_lvl, eff_lvl_q; // {cd,ri,dsr,cts}
    always_comb begin
        if (loop_mode) begin
            eff_lvl = {modem_output_ctrl_reg[MOC_OUT2], modem_output_ctrl_reg[MOC_OUT1],
                       modem_output_ctrl_reg[MOC_DTR], modem_output_ctrl_reg[MOC_RTS]};
        end else begin
            eff_lvl = ~pin_lvl; // R07
        end
    end

    // register writes and change-flag updates
    always_comb begin
        next_enable = event_enable_reg;
        next_queue = queue_ctrl_reg;
        next_format = line_format_reg;
        next_moctl = modem_output_ctrl_reg;
        next_scratch = scratch_byte_reg;
        next_dll = divisor_low_byte;
        next_dlm = divisor_high_byte;
        next_flags = change_flags;
        // read of status clears flags; events below win over the clear
        if (rd_hit && host.addr == ADDR_MSTATE) begin
            next_flags = 4'h0; // R16
        end
        if (lvl_primed) begin
            if (eff_lvl[0] != eff_lvl_q[0]) next_flags[0] = 1'b1; // R14
            if (eff_lvl[1] != eff_lvl_q[1]) next_flags[1] = 1'b1; // R14
            if (!eff_lvl[2] && eff_lvl_q[2]) next_flags[2] = 1'b1; // R15
            if (eff_lvl[3] != eff_lvl_q[3]) next_flags[3] = 1'b1; // R01
        end
        if (wr_hit) begin
            unique case (host.addr)
                ADDR_RX_TX: if (dlab) next_dll = host.wdata;
                ADDR_ENABLE: begin
                    if (dlab) next_dlm = host.wdata;
                    else next_enable = {4'h0, host.wdata[3:0]};
                end
                ADDR_SOURCE: next_queue = host.wdata;
                ADDR_FORMAT: next_format = host.wdata;
                ADDR_MOCTL: next_moctl = {3'h0, host.wdata[4:0]};
                ADDR_LSTATE: next_format = line_format_reg; // write accepted, no effect
                ADDR_MSTATE: next_flags = host.wdata[3:0] | next_flags;
                ADDR_SCRATCH: next_scratch = host.wdata; // R08
            endcase
        end
    end

    // registers loaded with their reset values
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            event_enable_reg <= RST_ENABLE; // R11
            queue_ctrl_reg <= RST_QUEUE; // R11
            line_format_reg <= RST_FORMAT; // R11
            modem_output_ctrl_reg <= RST_MOCTL; // R11
            scratch_byte_reg <= RST_SCRATCH; // R11
            change_flags <= 4'h0; // R12
            pin_lvl <= 4'hf;
            eff_lvl_q <= 4'h0;
            prime_cnt <= 3'h0; // R12
        end else begin
            event_enable_reg <= next_enable;
            queue_ctrl_reg <= next_queue;
            line_format_reg <= next_format;
            modem_output_ctrl_reg <= next_moctl;
            scratch_byte_reg <= next_scratch;
            change_flags <= next_flags;
            pin_lvl <= next_pin_lvl;
            eff_lvl_q <= eff_lvl;
            prime_cnt <= next_prime_cnt;
        end
    end

    // divisor latches have no reset at all
    always_ff @(posedge core_clk) begin
        divisor_low_byte <= next_dll; // R10
        divisor_high_byte <= next_dlm; // R10
    end
    assign baud_divisor = {divisor_high_byte, divisor_low_byte}; // R09

    // transmit gating: a loaded character runs to its end even if clear-to-send
    // drops; the next one waits until the input is active again
    logic tx_busy, next_busy; // a loaded character is still being shifted
    always_comb begin
        next_busy = tx_busy;
        if (tx_load) next_busy = 1'b1; // R02
        else if (char_done) next_busy = 1'b0; // R02
    end
    // register the busy state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_busy <= 1'b0;
        end else begin
            tx_busy <= next_busy;
        end
    end
    assign tx_enable = eff_lvl[0] || tx_busy; // R02

    // transmit holding byte strobe
    logic [7:0] next_thb;
    always_comb begin
        next_thb = tx_hold_byte;
        if (wr_hit && host.addr == ADDR_RX_TX && !dlab) next_thb = host.wdata;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_hold_byte <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            tx_hold_byte <= next_thb;
            tx_load <= wr_hit && host.addr == ADDR_RX_TX && !dlab;
        end
    end

    // modem event pending and source code
    logic modem_event;
    assign modem_event = event_enable_reg[EN_MODEM] && (change_flags != 4'h0); // R01
    logic [7:0] source_val;
    assign source_val = modem_event ? SOURCE_MODEM : RST_SOURCE;

    // read data register
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (host.addr)
            ADDR_RX_TX: next_rdata = dlab ? divisor_low_byte : rx_hold_byte;
            ADDR_ENABLE: next_rdata = dlab ? divisor_high_byte : event_enable_reg;
            ADDR_SOURCE: next_rdata = source_val;
            ADDR_FORMAT: next_rdata = line_format_reg;
            ADDR_MOCTL: next_rdata = modem_output_ctrl_reg;
            ADDR_LSTATE: next_rdata = RST_LSTATE;
            ADDR_MSTATE: next_rdata = {eff_lvl, change_flags}; // R03 R04 R05 R06 R07
            ADDR_SCRATCH: next_rdata = scratch_byte_reg; // R08
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) rdata <= 8'h00;
        else if (rd_hit) rdata <= next_rdata;
    end

    // pin outputs
    logic event_level;
    assign event_level = modem_event || rx_event;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_tx_out <= 1'b1; // R17
            infrared_tx_out <= 1'b0; // R17
            rts_out_n <= 1'b1; // R17
            dtr_out_n <= 1'b1; // R17
            rx_dma_request_n <= 1'b1; // R17
            tx_dma_request_n <= 1'b0; // R17
            event_out <= 1'b0; // R13
            irq_out_n <= 1'b1; // R13
        end else begin
            serial_tx_out <= 1'b1;
            infrared_tx_out <= 1'b0;
            rts_out_n <= loop_mode | ~modem_output_ctrl_reg[MOC_RTS];
            dtr_out_n <= loop_mode | ~modem_output_ctrl_reg[MOC_DTR];
            rx_dma_request_n <= 1'b1;
            tx_dma_request_n <= 1'b0;
            event_out <= event_level;
            irq_out_n <= ~event_level;
        end
    end
    // line enable follows the select pin at once, during reset as well
    assign event_out_oe = CONTINUOUS_EVENT || event_line_drive_select
                          || modem_output_ctrl_reg[MOC_OUT2]; // R13
endmodule

// >>> tb/ums_modem_model.sv
// handshake line model: pins follow the commanded levels after a chosen lag
module ums_modem_model
    import ums_pkg::*;
(
    input wire logic core_clk,
    input wire logic [1:0] lag,
    input wire ums_pkg::ums_modem_t want,
    output ums_pkg::ums_modem_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import ums_pkg::*;
    ums_modem_t dly [0:2]; // delay taps of the commanded levels
    // shift the commanded levels so a slow modem can be mimicked
    always_ff @(posedge core_clk) begin
        dly[0] <= want;
        dly[1] <= dly[0];
        dly[2] <= dly[1];
    end
    // lines are always driven, so no float value is ever shown
    assign pins = (lag == 2'd0) ? want : dly[lag - 2'd1];
endmodule

// >>> tb/ums_channel_props.sv
// port checker for the modem status channel
module ums_channel_props
    import ums_pkg::*;
#(
    parameter bit CONTINUOUS_EVENT = 1'b0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire ums_pkg::ums_host_t host,
    input wire logic [7:0] rdata,
    input wire ums_pkg::ums_modem_t modem_pins,
    input wire logic event_line_drive_select,
    input wire logic tx_enable,
    input wire logic [15:0] baud_divisor,
    input wire logic event_out_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import ums_pkg::*;
    logic [7:0] moc; // mirrored output control
    logic dlab; // mirrored divisor select
    logic [15:0] div_seen; // divisor seen before a reset
    logic [1:0] div_wr = 2'h0; // divisor bytes written since power-up
    logic [3:0] lvl; // expected level nibble
    logic oe_exp; // expected event line enable
    // level nibble comes from the pins or, in loopback, from output control
    always_comb begin
        lvl = moc[MOC_LOOP] ? {moc[MOC_OUT2], moc[MOC_OUT1], moc[MOC_DTR], moc[MOC_RTS]}
                            : ~modem_pins;
        oe_exp = CONTINUOUS_EVENT | event_line_drive_select | moc[MOC_OUT2];
    end
    // track host writes to output control and line format
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            moc <= 8'h00;
            dlab <= 1'b0;
        end else if (host.sel && host.wr && host.addr == ADDR_MOCTL) begin
            moc <= host.wdata;
        end else if (host.sel && host.wr && host.addr == ADDR_FORMAT) begin
            dlab <= host.wdata[FMT_DLAB];
        end
    end
    // divisor value held while out of reset, and which bytes were ever written
    always_ff @(posedge core_clk) begin
        if (arst_n) begin
            div_seen <= baud_divisor;
            if (host.sel && host.wr && dlab && host.addr == ADDR_RX_TX) div_wr[0] <= 1'b1;
            if (host.sel && host.wr && dlab && host.addr == ADDR_ENABLE) div_wr[1] <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd(a); host.sel && host.rd && host.addr == a; endsequence
    sequence s_wr(a); host.sel && host.wr && host.addr == a; endsequence
    property p_scratch; s_wr(ADDR_SCRATCH) ##1 s_rd(ADDR_SCRATCH) |=> rdata == $past(host.wdata, 2);
    endproperty
    property p_level; $stable(lvl)[*7] ##0 s_rd(ADDR_MSTATE) |=> rdata[7:4] == $past(lvl);
    endproperty
    property p_flags; $stable(lvl)[*8] ##0 s_rd(ADDR_MSTATE) ##1 s_rd(ADDR_MSTATE) |=> rdata[3:0] == 4'h0;
    endproperty
    property p_div_lo; s_wr(ADDR_RX_TX) ##0 dlab |=> baud_divisor[7:0] == $past(host.wdata); endproperty
    property p_div_hi; s_wr(ADDR_ENABLE) ##0 dlab |=> baud_divisor[15:8] == $past(host.wdata); endproperty
    property p_div_keep; $rose(arst_n) && (&div_wr) |-> baud_divisor == div_seen; endproperty
    property p_tx_go; $stable(lvl)[*7] ##0 lvl[0] |-> tx_enable; endproperty
    property p_oe; $stable(oe_exp)[*6] |-> event_out_oe == oe_exp; endproperty
    a_scratch: assert property (p_scratch) else $error("scratch readback differs");
    a_level: assert property (p_level) else $error("status levels differ");
    a_flags: assert property (p_flags) else $error("flags kept after read");
    a_div_lo: assert property (p_div_lo) else $error("divisor low byte wrong");
    a_div_hi: assert property (p_div_hi) else $error("divisor high byte wrong");
    a_div_keep: assert property (p_div_keep) else $error("divisor lost on reset");
    a_tx_go: assert property (p_tx_go) else $error("transmit not resumed");
    a_oe: assert property (p_oe) else $error("event line enable wrong");
endmodule
bind ums_channel ums_channel_props #(.CONTINUOUS_EVENT(CONTINUOUS_EVENT)) props_i (
    .core_clk(core_clk), .arst_n(arst_n), .host(host), .rdata(rdata), .modem_pins(modem_pins),
    .event_line_drive_select(event_line_drive_select), .tx_enable(tx_enable),
    .baud_divisor(baud_divisor), .event_out_oe(event_out_oe));

// >>> tb/ums_channel_tb.sv
// self-checking bench for the modem status channel
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module ums_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ums_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, sel_in = 1'b0, char_done = 1'b0;
    ums_host_t host = '0; // host strobes
    ums_modem_t want = 4'b1110, pins; // commanded and actual modem lines
    logic [1:0] lag = 2'd0; // modem answer lag
    logic [7:0] rdata;
    logic [15:0] baud_divisor;
    logic tx_enable, serial_tx_out, infrared_tx_out, rts_out_n, dtr_out_n;
    logic rx_dma_request_n, tx_dma_request_n, event_out, event_out_oe, irq_out_n;
    logic [8:0] pinv; // idle pin levels
    logic [7:0] tx_hold_byte, line_format_reg, queue_ctrl_reg; // register outputs
    logic tx_load; // character load strobe
    int bad_count = 0, checks = 0;
    logic [7:0] rst_exp [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h10, 8'hff};
    logic [3:0] loop_exp [4] = '{4'h2, 4'h1, 4'h4, 4'h8}; // dtr, rts, out1, out2
    ums_modem_t seq_want [4] = '{4'b0110, 4'b0010, 4'b0110, 4'b0101};
    logic [7:0] seq_exp [4] = '{8'h98, 8'hd0, 8'h94, 8'ha3};
    assign pinv = {serial_tx_out, infrared_tx_out, rts_out_n, dtr_out_n, rx_dma_request_n,
                   tx_dma_request_n, event_out_oe, event_out, irq_out_n};
    ums_channel uut (.core_clk(core_clk), .arst_n(arst_n), .host(host), .rdata(rdata),
        .modem_pins(pins), .event_line_drive_select(sel_in), .char_done(char_done),
        .rx_event(1'b0), .rx_hold_byte(8'h00), .tx_enable(tx_enable),
        .tx_hold_byte(tx_hold_byte), .tx_load(tx_load), .baud_divisor(baud_divisor),
        .line_format_reg(line_format_reg), .queue_ctrl_reg(queue_ctrl_reg),
        .serial_tx_out(serial_tx_out), .infrared_tx_out(infrared_tx_out),
        .rts_out_n(rts_out_n), .dtr_out_n(dtr_out_n), .rx_dma_request_n(rx_dma_request_n),
        .tx_dma_request_n(tx_dma_request_n), .event_out(event_out),
        .event_out_oe(event_out_oe), .irq_out_n(irq_out_n));
    ums_modem_model peer (.core_clk(core_clk), .lag(lag), .want(want), .pins(pins));
    // clock at 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // one host access, held for one rising edge
    task automatic op(input logic r, input logic [2:0] a, input logic [7:0] d);
        host = '{sel: 1'b1, rd: r, wr: !r, addr: a, wdata: d};
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        op(1'b0, a, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        op(1'b1, a, 8'h00);
        `CHK(rdata, e)
    endtask
    task automatic idle(input int n);
        host.sel = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask
    task automatic final_report();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(negedge core_clk);
        `CHK(pinv, 9'h171)
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        idle(8);
        `CHK({line_format_reg, queue_ctrl_reg}, 16'h0000)
        for (int i = 0; i < 7; i++) begin
            rd(3'(i + 1), rst_exp[i]);
        end
        wr(ADDR_SCRATCH, 8'ha5);
        rd(ADDR_SCRATCH, 8'ha5);
        wr(ADDR_FORMAT, 8'h80);
        wr(ADDR_RX_TX, 8'h34);
        wr(ADDR_ENABLE, 8'h12);
        rd(ADDR_ENABLE, 8'h12);
        idle(1);
        `CHK(baud_divisor, 16'h1234)
        arst_n = 1'b0;
        sel_in = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK({event_out_oe, event_out, irq_out_n}, 3'b101)
        sel_in = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        `CHK(baud_divisor, 16'h1234)
        idle(8);
        rd(ADDR_FORMAT, 8'h00);
        rd(ADDR_SCRATCH, 8'hff);
        // loopback: each output control bit shows in one level bit
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_MOCTL, 8'h10 | 8'(1 << b));
            idle(8);
            op(1'b1, ADDR_MSTATE, 8'h00);
            `CHK(rdata[7:4], loop_exp[b])
        end
        wr(ADDR_MOCTL, 8'h00);
        idle(12);
        op(1'b1, ADDR_MSTATE, 8'h00);
        wr(ADDR_ENABLE, 8'h08);
        // pin changes with the modem answering promptly, then slower
        for (int i = 0; i < 4; i++) begin
            want = seq_want[i];
            lag = 2'(i);
            idle(12);
            if (i == 0) begin
                `CHK({event_out, irq_out_n}, 2'b10)
                rd(ADDR_SOURCE, SOURCE_MODEM);
            end
            rd(ADDR_MSTATE, seq_exp[i]);
            rd(ADDR_MSTATE, seq_exp[i] & 8'hf0);
        end
        rd(ADDR_SOURCE, 8'h01);
        `CHK(tx_enable, 1'b0)
        want = 4'b0100;
        idle(12);
        `CHK(tx_enable, 1'b1)
        wr(ADDR_RX_TX, 8'h55);
        `CHK({tx_load, tx_hold_byte}, 9'h155)
        want = 4'b0101;
        idle(12);
        `CHK(tx_enable, 1'b1)
        char_done = 1'b1;
        idle(1);
        char_done = 1'b0;
        idle(2);
        `CHK(tx_enable, 1'b0)
        sel_in = 1'b1;
        idle(8);
        `CHK(event_out_oe, 1'b1)
        final_report();
    end
endmodule
